// file: rtl/t3rie_status_irq.sv
`timescale 1ns/10ps
`include "t3rie_params.svh"
module t3rie_status_irq (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire t3rie_pkg::t3rie_addr_type paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Live receive conditions (bit 5 unused; alignment change is an event).
   input wire t3rie_pkg::t3rie_word_type live_status_one,
   input wire logic align_change_event,
   // Error events, one-cycle pulses.
   input wire logic cbit_parity_event,
   input wire logic far_block_err_event,
   input wire logic pbit_parity_event,
   input wire logic framing_err_event,
   // Count-nonzero indicators.
   input wire logic cbit_count_nonzero,
   input wire logic far_block_count_nonzero,
   input wire logic pbit_count_nonzero,
   input wire logic framing_count_nonzero,
   // Port interrupt.
   output logic port_irq
);
   import t3rie_pkg::*;

   t3rie_word_type rx_status_irq_enable_one;
   t3rie_word_type rx_status_irq_enable_two;
   t3rie_word_type latched_one;
   t3rie_word_type latched_two;
   t3rie_word_type live_prev;
   logic [3:0] count_prev;
   logic [1:0] control;
   logic port_status_irq_enable;
   logic mux_framing_mode;
   logic wr_strobe;
   logic rd_strobe;
   logic addr_hit;
   t3rie_word_type set_one;
   t3rie_word_type set_two;
   t3rie_word_type clr_one;
   t3rie_word_type clr_two;
   t3rie_word_type read_word;
   logic [3:0] count_now;

   assign port_status_irq_enable = control[`T3RIE_BIT_PORT_EN];
   assign mux_framing_mode = control[`T3RIE_BIT_MUX_MODE];
   assign count_now = {cbit_count_nonzero, far_block_count_nonzero, pbit_count_nonzero, framing_count_nonzero};

   // Every access completes in its first access cycle.
   assign pready = 1'b1;
   assign wr_strobe = psel && penable && pwrite;
   assign rd_strobe = psel && penable && !pwrite;

   function automatic logic is_mapped(input t3rie_addr_type a);
      is_mapped = (a == `T3RIE_ADDR_ENABLE_ONE) || (a == `T3RIE_ADDR_ENABLE_TWO) ||
         (a == `T3RIE_ADDR_LATCHED_ONE) || (a == `T3RIE_ADDR_LATCHED_TWO) ||
         (a == `T3RIE_ADDR_LIVE_ONE) || (a == `T3RIE_ADDR_LIVE_TWO) || (a == `T3RIE_ADDR_CONTROL);
   endfunction : is_mapped

   assign addr_hit = is_mapped(paddr);
   assign pslverr = psel && penable && !addr_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_status_irq_enable_one <= `T3RIE_RESET_ENABLE;
         rx_status_irq_enable_two <= `T3RIE_RESET_ENABLE;
         control <= `T3RIE_RESET_CONTROL;
      end else if (wr_strobe) begin
         if (paddr == `T3RIE_ADDR_ENABLE_ONE) begin
            rx_status_irq_enable_one <= pwdata[15:0] & `T3RIE_MASK_ONE; // RL25
         end
         if (paddr == `T3RIE_ADDR_ENABLE_TWO) begin
            rx_status_irq_enable_two <= pwdata[15:0] & `T3RIE_MASK_TWO; // RL25
         end
         if (paddr == `T3RIE_ADDR_CONTROL) begin
            control <= pwdata[1:0];
         end
      end
   end

   // Edge history; reset to zero so a condition already active after reset counts as a change.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_prev <= 16'h0000;
         count_prev <= 4'h0;
      end else begin
         live_prev <= live_status_one & `T3RIE_MASK_LIVE_ONE;
         count_prev <= count_now;
      end
   end

   always_comb begin
      set_one = (live_status_one & `T3RIE_MASK_LIVE_ONE) ^ live_prev; // RL21
      set_one[`T3RIE_BIT_ALIGN] = align_change_event;
      set_two = 16'h0000;
      set_two[`T3RIE_BIT_CBIT_ERR] = cbit_parity_event;
      set_two[`T3RIE_BIT_FAR_ERR] = far_block_err_event;
      set_two[`T3RIE_BIT_PBIT_ERR] = pbit_parity_event;
      set_two[`T3RIE_BIT_FRAME_ERR] = framing_err_event;
      set_two[3:0] = count_now & ~count_prev; // RL22
      // Writing one to a latched bit clears it.
      clr_one = 16'h0000;
      clr_two = 16'h0000;
      if (wr_strobe && paddr == `T3RIE_ADDR_LATCHED_ONE) begin
         clr_one = pwdata[15:0];
      end
      if (wr_strobe && paddr == `T3RIE_ADDR_LATCHED_TWO) begin
         clr_two = pwdata[15:0];
      end
   end

   // A set arriving with its clear wins, so no event is lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_one <= 16'h0000;
         latched_two <= 16'h0000;
      end else begin
         latched_one <= ((latched_one & ~clr_one) | set_one) & `T3RIE_MASK_ONE;
         if (mux_framing_mode) begin
            latched_two <= ((latched_two & ~clr_two) | set_two) & `T3RIE_MASK_TWO & ~`T3RIE_MASK_CBIT_TWO; // RL23
         end else begin
            latched_two <= ((latched_two & ~clr_two) | set_two) & `T3RIE_MASK_TWO;
         end
      end
   end

   // Bits 11..0 of register one and 11..8, 3..0 of register two each gate one source.
   // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8 RL9 RL10 RL11 RL12
   // RL13 RL14 RL15 RL16 RL17 RL18 RL19 RL20
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_irq <= 1'b0;
      end else begin
         port_irq <= port_status_irq_enable &&
            (|(latched_one & rx_status_irq_enable_one) || |(latched_two & rx_status_irq_enable_two)); // RL24
      end
   end

   always_comb begin
      case (paddr)
         `T3RIE_ADDR_ENABLE_ONE: read_word = rx_status_irq_enable_one;
         `T3RIE_ADDR_ENABLE_TWO: read_word = rx_status_irq_enable_two;
         `T3RIE_ADDR_LATCHED_ONE: read_word = latched_one;
         `T3RIE_ADDR_LATCHED_TWO: read_word = latched_two;
         `T3RIE_ADDR_LIVE_ONE: read_word = live_prev;
         `T3RIE_ADDR_LIVE_TWO: read_word = {12'h000, count_prev};
         `T3RIE_ADDR_CONTROL: read_word = {14'h0000, control};
         default: read_word = 16'h0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {16'h0000, read_word};
      end
   end
endmodule : t3rie_status_irq

// file: rtl/t3rie_params.svh
// Contract
// RL1 - Format mismatch latch, its enable bit 11 and port enable raise the interrupt.
// RL2 - App channel change latch, enable bit 10 and port enable raise the interrupt.
// RL3 - Idle change latch, enable bit 9 and port enable raise the interrupt.
// RL4 - Unframed all-ones change latch, enable bit 8 and port enable raise it.
// RL5 - Multiframe loss change latch, enable bit 7 and port enable raise it.
// RL6 - Severe frame error change latch, enable bit 6 and port enable raise it.
// RL7 - Alignment change latch, enable bit 5 and port enable raise it.
// RL8 - Frame loss change latch, enable bit 4 and port enable raise it.
// RL9 - Remote defect change latch, enable bit 3 and port enable raise it.
// RL10 - Alarm signal change latch, enable bit 2 and port enable raise it.
// RL11 - Out-of-frame change latch, enable bit 1 and port enable raise it.
// RL12 - Signal loss change latch, enable bit 0 and port enable raise it.
// RL13 - Second register bit 11 gates the C-bit parity error latch.
// RL14 - Second register bit 10 gates the far-end block error latch.
// RL15 - Second register bit 9 gates the P-bit parity error latch.
// RL16 - Second register bit 8 gates the framing error latch.
// RL17 - Second register bit 3 gates the C-bit count-nonzero latch.
// RL18 - Second register bit 2 gates the far-end block count-nonzero latch.
// RL19 - Second register bit 1 gates the P-bit count-nonzero latch.
// RL20 - Second register bit 0 gates the framing count-nonzero latch.
// RL21 - A condition latch sets when its live condition changes either way.
// RL22 - A count latch sets only when its nonzero indicator rises.
// RL23 - C-bit and far-end latches and their count latches stay zero in mux framing mode.
// RL24 - Interrupt is OR of enabled latched sources, gated by port enable, held until cleared.
// RL25 - Reserved enable bits read zero and ignore writes.
`ifndef T3RIE_PARAMS_SVH
`define T3RIE_PARAMS_SVH
// Register indices; each register owns one aligned 32-bit word, so the byte address is four times the index.
`define T3RIE_IDX_ENABLE_ONE 12'h12c
`define T3RIE_IDX_ENABLE_TWO 12'h12e
`define T3RIE_IDX_LATCHED_ONE 12'h128
`define T3RIE_IDX_LATCHED_TWO 12'h12a
`define T3RIE_IDX_LIVE_ONE 12'h124
`define T3RIE_IDX_LIVE_TWO 12'h126
`define T3RIE_IDX_CONTROL 12'h140
`define T3RIE_ADDR_ENABLE_ONE 12'h4b0
`define T3RIE_ADDR_ENABLE_TWO 12'h4b8
`define T3RIE_ADDR_LATCHED_ONE 12'h4a0
`define T3RIE_ADDR_LATCHED_TWO 12'h4a8
`define T3RIE_ADDR_LIVE_ONE 12'h490
`define T3RIE_ADDR_LIVE_TWO 12'h498
`define T3RIE_ADDR_CONTROL 12'h500
`define T3RIE_MASK_ONE 16'h0fff
`define T3RIE_MASK_TWO 16'h0f0f
`define T3RIE_MASK_LIVE_ONE 16'h0fdf
`define T3RIE_MASK_CBIT_TWO 16'h0c0c
`define T3RIE_RESET_ENABLE 16'h0000
`define T3RIE_RESET_CONTROL 2'h0
`define T3RIE_BIT_PORT_EN 0
`define T3RIE_BIT_MUX_MODE 1
`define T3RIE_BIT_FORMAT 11
`define T3RIE_BIT_ALIGN 5
`define T3RIE_BIT_CBIT_ERR 11
`define T3RIE_BIT_FAR_ERR 10
`define T3RIE_BIT_PBIT_ERR 9
`define T3RIE_BIT_FRAME_ERR 8
`define T3RIE_BIT_CBIT_CNT 3
`define T3RIE_BIT_FAR_CNT 2
`define T3RIE_BIT_PBIT_CNT 1
`define T3RIE_BIT_FRAME_CNT 0
`endif

// file: rtl/t3rie_pkg.sv
package t3rie_pkg;
   typedef logic [15:0] t3rie_word_type;
   typedef logic [11:0] t3rie_addr_type;
endpackage : t3rie_pkg

// file: verification/t3rie_chk.sv
`timescale 1ns/10ps
`include "t3rie_params.svh"
module t3rie_chk (
   // Bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire t3rie_pkg::t3rie_addr_type paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupt.
   input wire logic port_irq
);
   import t3rie_pkg::*;
   logic hit;
   assign hit = paddr inside {`T3RIE_ADDR_ENABLE_ONE, `T3RIE_ADDR_ENABLE_TWO, `T3RIE_ADDR_LATCHED_ONE,
      `T3RIE_ADDR_LATCHED_TWO, `T3RIE_ADDR_LIVE_ONE, `T3RIE_ADDR_LIVE_TWO, `T3RIE_ADDR_CONTROL};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s; psel && penable; endsequence
   sequence rd_s(a); psel && penable && !pwrite && paddr == a; endsequence
   sequence bad_rd_s; psel && !penable && !pwrite && !hit ##1 psel && penable; endsequence
   zero_wait_a: assert property (pready) else $error("pready low");
   err_exact_a: assert property (pslverr == (psel && penable && !hit)) else $error("error flag wrong");
   upper_zero_a: assert property (acc_s ##0 !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   bad_rd_a: assert property (bad_rd_s |-> prdata == 32'h0) else $error("unmapped read not zero");
   rsvd_one_a: assert property (rd_s(`T3RIE_ADDR_ENABLE_ONE) |-> (prdata[15:0] & ~`T3RIE_MASK_ONE) == 16'h0)
      else $error("reserved bit set in first enable");
   rsvd_two_a: assert property (rd_s(`T3RIE_ADDR_ENABLE_TWO) |-> (prdata[15:0] & ~`T3RIE_MASK_TWO) == 16'h0)
      else $error("reserved bit set in second enable");
   port_off_a: assert property (acc_s ##0 pwrite && paddr == `T3RIE_ADDR_CONTROL && !pwdata[0] |-> ##2 !port_irq)
      else $error("interrupt with port disabled");
   reset_idle_a: assert property ($rose(presetn) |-> !port_irq && prdata == 32'h0)
      else $error("outputs not idle after reset");
endmodule : t3rie_chk
bind t3rie_status_irq t3rie_chk i_t3rie_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_irq(port_irq));

// file: verification/t3rie_host.sv
`timescale 1ns/10ps
module t3rie_host (
   // Bus.
   input wire logic pclk,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output t3rie_pkg::t3rie_addr_type paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0,
   input wire logic [31:0] prdata,
   input wire logic pready
);
   import t3rie_pkg::*;
   // The request is held until pready is seen high, so a slow slave is served too.
   task automatic xfer(input logic wr, input t3rie_addr_type a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps the next call from driving psel twice in one time step.
      @(posedge pclk);
   endtask : xfer
endmodule : t3rie_host

// file: verification/test_t3_rx_status_irq_enable.sv
`timescale 1ns/10ps
`include "t3rie_params.svh"
module test_t3_rx_status_irq_enable;
   import t3rie_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, port_irq, aev, pe, mux, irq;
   t3rie_addr_type paddr;
   logic [31:0] pwdata, prdata, q, m, seed;
   t3rie_word_type live, e1, e2, l1, l2;
   logic [3:0] ev, cnt;
   logic [16:0] expq[$];
   int err_count, num_checks, k;
   t3rie_status_irq i_t3rie_status_irq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .live_status_one(live), .align_change_event(aev), .cbit_parity_event(ev[3]), .far_block_err_event(ev[2]),
      .pbit_parity_event(ev[1]), .framing_err_event(ev[0]), .cbit_count_nonzero(cnt[3]),
      .far_block_count_nonzero(cnt[2]), .pbit_count_nonzero(cnt[1]), .framing_count_nonzero(cnt[0]),
      .port_irq(port_irq));
   t3rie_host i_t3rie_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic wr(input t3rie_addr_type a, input logic [31:0] d);
      i_t3rie_host.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input t3rie_addr_type a, input logic [15:0] e, input logic i);
      expq.push_back({i, e});
      i_t3rie_host.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #20000;
      err_count++;
      finish_test();
   end
   // Read data and the interrupt line are judged together when each read completes.
   always @(posedge pclk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) check({port_irq, prdata[15:0]}, expq.pop_front());
   end
   initial begin
      {presetn, live, ev, cnt, aev, err_count, num_checks} = '0;
      seed = 32'h5813;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`T3RIE_ADDR_ENABLE_ONE, 16'h0000, 1'b0);
      rd(`T3RIE_ADDR_ENABLE_TWO, 16'h0000, 1'b0);
      wr(`T3RIE_ADDR_ENABLE_ONE, 32'hffffffff);
      wr(`T3RIE_ADDR_ENABLE_TWO, 32'hffffffff);
      rd(`T3RIE_ADDR_ENABLE_ONE, `T3RIE_MASK_ONE, 1'b0);
      rd(`T3RIE_ADDR_ENABLE_TWO, `T3RIE_MASK_TWO, 1'b0);
      rd(12'h130, 16'h0000, 1'b0);
      // Each pass enables one bit position, including reserved ones, and fires random sources.
      for (k = 0; k < 32; k++) begin
         seed = xs(seed);
         m = seed;
         pe = (k % 8) != 7;
         mux = m[21];
         e1 = (k < 16) ? 16'h0001 << k : 16'h0000;
         e2 = (k >= 16) ? 16'h0001 << (k - 16) : 16'h0000;
         cnt <= 4'h0;
         wr(`T3RIE_ADDR_CONTROL, {30'h0, mux, pe});
         wr(`T3RIE_ADDR_LATCHED_ONE, 32'hffff);
         wr(`T3RIE_ADDR_LATCHED_TWO, 32'hffff);
         wr(`T3RIE_ADDR_ENABLE_ONE, {16'h0, e1});
         wr(`T3RIE_ADDR_ENABLE_TWO, {16'h0, e2});
         live <= live ^ m[15:0];
         {aev, ev, cnt} <= {m[28], m[19:16], m[27:24]};
         @(posedge pclk);
         {aev, ev} <= 5'h00;
         repeat (2) @(posedge pclk);
         l1 = (m[15:0] & `T3RIE_MASK_LIVE_ONE) | {10'h0, m[28], 5'h0};
         l2 = {4'h0, m[19:16], 4'h0, m[27:24]} & (mux ? ~`T3RIE_MASK_CBIT_TWO : 16'hffff);
         irq = pe & |((e1 & `T3RIE_MASK_ONE & l1) | (e2 & `T3RIE_MASK_TWO & l2));
         rd(`T3RIE_ADDR_LATCHED_ONE, l1, irq);
         rd(`T3RIE_ADDR_LATCHED_TWO, l2, irq);
      end
      repeat (2) @(posedge pclk);
      finish_test();
   end
endmodule : test_t3_rx_status_irq_enable
